// File: design/mwh_consts.svh
`ifndef MWH_CONSTS_SVH
`define MWH_CONSTS_SVH

// ----------------------------------------
// bus clock
// ----------------------------------------
`define MWH_CLK_PERIOD_NS 25

// ----------------------------------------
// transfer sizes
// ----------------------------------------
`define MWH_BURST_WORDS   3'h4
`define MWH_SINGLE_WORDS  3'h1
`define MWH_BUF_DEPTH     4
`define MWH_BUF_IDX_W     2
`define MWH_DATA_W        32
`define MWH_ADDR_W        32

// ----------------------------------------
// address layout
// ----------------------------------------
`define MWH_PAGE_LSB      10
`define MWH_WORD_LSB      2
`define MWH_INT_W         6

// ----------------------------------------
// reset values
// ----------------------------------------
`define MWH_STROBE_IDLE   1'h1
`define MWH_ZERO_WORD     32'h0000_0000

`endif

// File: design/mwh_pkg.sv
package mwh_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_READ  = 4'h2,
        ST_WRITE = 4'h4,
        ST_DRAIN = 4'h8
    } mwh_state_t;

endpackage

// File: design/mwh_read_buffer.sv
`timescale 1ns/1ps
`default_nettype none
`include "mwh_consts.svh"

module mwh_read_buffer (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     flush,
    input  wire logic                     push,
    input  wire logic [`MWH_DATA_W-1:0]   pushData,
    input  wire logic                     pop,
    output logic                          notEmpty,
    output logic [`MWH_DATA_W-1:0]        popData,
    output logic                          popValid
);

    logic [`MWH_DATA_W-1:0]   mem_ff [`MWH_BUF_DEPTH];
    logic [`MWH_DATA_W-1:0]   nxt_mem [`MWH_BUF_DEPTH];
    logic [`MWH_BUF_IDX_W:0]  wrPtr_ff, nxt_wrPtr;
    logic [`MWH_BUF_IDX_W:0]  rdPtr_ff, nxt_rdPtr;
    logic [`MWH_DATA_W-1:0]   popData_ff, nxt_popData;
    logic                     popValid_ff, nxt_popValid;
    logic                     doPop;

    assign notEmpty = (wrPtr_ff != rdPtr_ff);
    assign doPop    = pop && notEmpty;
    assign popData  = popData_ff;
    assign popValid = popValid_ff;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_mem      = mem_ff;
        nxt_wrPtr    = wrPtr_ff;
        nxt_rdPtr    = rdPtr_ff;
        nxt_popData  = popData_ff;
        nxt_popValid = doPop;
        if (push) begin
            nxt_mem[wrPtr_ff[`MWH_BUF_IDX_W-1:0]] = pushData;
            nxt_wrPtr = wrPtr_ff + 1'b1;
        end
        if (doPop) begin
            nxt_popData = mem_ff[rdPtr_ff[`MWH_BUF_IDX_W-1:0]];
            nxt_rdPtr   = rdPtr_ff + 1'b1;
        end
        if (flush) begin
            nxt_wrPtr    = '0;
            nxt_rdPtr    = '0;
            nxt_popValid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `MWH_BUF_DEPTH; i++) begin
                mem_ff[i] <= `MWH_ZERO_WORD;
            end
            wrPtr_ff    <= '0;
            rdPtr_ff    <= '0;
            popData_ff  <= `MWH_ZERO_WORD;
            popValid_ff <= 1'b0;
        end else begin
            mem_ff      <= nxt_mem;
            wrPtr_ff    <= nxt_wrPtr;
            rdPtr_ff    <= nxt_rdPtr;
            popData_ff  <= nxt_popData;
            popValid_ff <= nxt_popValid;
        end
    end

endmodule // mwh_read_buffer

`default_nettype wire

// File: design/mwh_bus_interface.sv
`timescale 1ns/1ps
`default_nettype none
`include "mwh_consts.svh"

module mwh_bus_interface (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    // core side
    input  wire logic                     reqValid,
    input  wire logic                     reqWrite,
    input  wire logic                     reqBurst,
    input  wire logic [`MWH_ADDR_W-1:0]   reqAddr,
    input  wire logic [`MWH_DATA_W-1:0]   reqWrData,
    output logic                          reqReady,
    output logic [`MWH_DATA_W-1:0]        rdData,
    output logic                          rdDataValid,
    output logic                          readFault,
    output logic                          storeDone,
    input  wire logic                     runState,
    output logic [`MWH_INT_W-1:0]         intLevel,
    // memory bus side
    output logic [`MWH_ADDR_W-1:0]        busAddr,
    output logic                          readStrobe_n,
    output logic                          storeStrobe_n,
    output logic                          burstOrPageHit_n,
    output logic                          busDriveEnable_n,
    input  wire logic [`MWH_DATA_W-1:0]   busDataIn,
    output logic [`MWH_DATA_W-1:0]        busDataOut,
    output logic                          busDataOe,
    input  wire logic                     readCaptureEnable_n,
    input  wire logic                     ack_n,
    input  wire logic                     busFaultInput_n,
    input  wire logic [`MWH_INT_W-1:0]    intIn_n
);

    localparam int SW = 3 + `MWH_INT_W + `MWH_DATA_W;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [SW-1:0] syncA_ff, syncB_ff;
    logic          capS, ackS, faultS;
    logic [`MWH_INT_W-1:0] intS;
    logic [`MWH_DATA_W-1:0] dataS;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA_ff <= {{3{1'b1}}, {`MWH_INT_W{1'b1}}, `MWH_ZERO_WORD};
            syncB_ff <= {{3{1'b1}}, {`MWH_INT_W{1'b1}}, `MWH_ZERO_WORD};
        end else begin
            syncA_ff <= {readCaptureEnable_n, ack_n, busFaultInput_n, intIn_n, busDataIn};
            syncB_ff <= syncA_ff;
        end
    end

    assign capS   = !syncB_ff[SW-1];
    assign ackS   = !syncB_ff[SW-2];
    assign faultS = !syncB_ff[SW-3];
    assign intS   = ~syncB_ff[`MWH_DATA_W +: `MWH_INT_W];
    assign dataS  = syncB_ff[`MWH_DATA_W-1:0];

    // ----------------------------------------
    // cycle state
    // ----------------------------------------
    mwh_pkg::mwh_state_t     state_ff, nxt_state;
    logic [2:0]              capCnt_ff, nxt_capCnt;
    logic [2:0]              drainCnt_ff, nxt_drainCnt;
    logic                    burst_ff, nxt_burst;
    logic                    rdStb_ff, nxt_rdStb;
    logic                    wrStb_ff, nxt_wrStb;
    logic                    bop_ff, nxt_bop;
    logic                    drv_ff, nxt_drv;
    logic [`MWH_ADDR_W-1:0]  addr_ff, nxt_addr;
    logic [`MWH_DATA_W-1:0]  wdata_ff, nxt_wdata;
    logic [`MWH_ADDR_W-1:`MWH_PAGE_LSB] page_ff, nxt_page;
    logic                    pageValid_ff, nxt_pageValid;
    logic                    rdFault_ff, nxt_rdFault;
    logic                    stDone_ff, nxt_stDone;
    logic [`MWH_INT_W-1:0]   int_ff, nxt_int;
    logic                    push, pop, flush, bufNotEmpty;
    logic [2:0]              expWords;

    assign expWords = burst_ff ? `MWH_BURST_WORDS : `MWH_SINGLE_WORDS;
    assign reqReady = (state_ff == mwh_pkg::ST_IDLE);

    always_comb begin
        nxt_state     = state_ff;
        nxt_capCnt    = capCnt_ff;
        nxt_drainCnt  = drainCnt_ff;
        nxt_burst     = burst_ff;
        nxt_rdStb     = rdStb_ff;
        nxt_wrStb     = wrStb_ff;
        nxt_bop       = bop_ff;
        nxt_drv       = drv_ff;
        nxt_addr      = addr_ff;
        nxt_wdata     = wdata_ff;
        nxt_page      = page_ff;
        nxt_pageValid = pageValid_ff;
        nxt_rdFault   = 1'b0;
        nxt_stDone    = 1'b0;
        push          = 1'b0;
        pop           = 1'b0;
        flush         = 1'b0;
        case (state_ff)
            mwh_pkg::ST_IDLE: begin
                if (reqValid) begin
                    nxt_addr = {reqAddr[`MWH_ADDR_W-1:`MWH_WORD_LSB], 2'h0};
                    if (reqWrite) begin
                        nxt_wdata     = reqWrData;
                        nxt_wrStb     = 1'b0;
                        nxt_drv       = 1'b0;
                        nxt_bop       = !(pageValid_ff && page_ff == reqAddr[`MWH_ADDR_W-1:`MWH_PAGE_LSB]);
                        nxt_page      = reqAddr[`MWH_ADDR_W-1:`MWH_PAGE_LSB];
                        nxt_pageValid = 1'b1;
                        nxt_state     = mwh_pkg::ST_WRITE;
                    end else begin
                        nxt_rdStb    = 1'b0;
                        nxt_burst    = reqBurst;
                        nxt_bop      = !reqBurst;
                        nxt_capCnt   = 3'h0;
                        nxt_drainCnt = 3'h0;
                        nxt_state    = mwh_pkg::ST_READ;
                    end
                end
            end
            mwh_pkg::ST_READ, mwh_pkg::ST_DRAIN: begin
                if (faultS) begin
                    nxt_rdStb   = 1'b1;
                    nxt_bop     = 1'b1;
                    nxt_rdFault = 1'b1;
                    flush       = 1'b1;
                    nxt_state   = mwh_pkg::ST_IDLE;
                end else begin
                    if (capS && capCnt_ff != expWords) begin
                        push       = 1'b1;
                        nxt_capCnt = capCnt_ff + 3'h1;
                        if (nxt_capCnt == expWords) begin
                            nxt_rdStb = 1'b1;
                            nxt_bop   = 1'b1;
                        end
                    end
                    if (state_ff == mwh_pkg::ST_READ) begin
                        if (ackS || nxt_capCnt == expWords) begin
                            nxt_state = mwh_pkg::ST_DRAIN;
                        end
                    end else begin
                        pop = bufNotEmpty;
                        if (bufNotEmpty) begin
                            nxt_drainCnt = drainCnt_ff + 3'h1;
                        end
                        if (nxt_drainCnt == expWords) begin
                            nxt_state = mwh_pkg::ST_IDLE;
                        end
                    end
                end
            end
            mwh_pkg::ST_WRITE: begin
                if (ackS || faultS) begin
                    nxt_wrStb  = 1'b1;
                    nxt_drv    = 1'b1;
                    nxt_bop    = 1'b1;
                    nxt_stDone = 1'b1;
                    nxt_state  = mwh_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = mwh_pkg::ST_IDLE;
                nxt_rdStb = 1'b1;
                nxt_wrStb = 1'b1;
                nxt_drv   = 1'b1;
                nxt_bop   = 1'b1;
                flush     = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff     <= mwh_pkg::ST_IDLE;
            capCnt_ff    <= 3'h0;
            drainCnt_ff  <= 3'h0;
            burst_ff     <= 1'b0;
            rdStb_ff     <= `MWH_STROBE_IDLE;
            wrStb_ff     <= `MWH_STROBE_IDLE;
            bop_ff       <= `MWH_STROBE_IDLE;
            drv_ff       <= `MWH_STROBE_IDLE;
            addr_ff      <= `MWH_ZERO_WORD;
            wdata_ff     <= `MWH_ZERO_WORD;
            page_ff      <= '0;
            pageValid_ff <= 1'b0;
            rdFault_ff   <= 1'b0;
            stDone_ff    <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            capCnt_ff    <= nxt_capCnt;
            drainCnt_ff  <= nxt_drainCnt;
            burst_ff     <= nxt_burst;
            rdStb_ff     <= nxt_rdStb;
            wrStb_ff     <= nxt_wrStb;
            bop_ff       <= nxt_bop;
            drv_ff       <= nxt_drv;
            addr_ff      <= nxt_addr;
            wdata_ff     <= nxt_wdata;
            page_ff      <= nxt_page;
            pageValid_ff <= nxt_pageValid;
            rdFault_ff   <= nxt_rdFault;
            stDone_ff    <= nxt_stDone;
        end
    end

    // ----------------------------------------
    // interrupt inputs
    // ----------------------------------------
    // re-register while running
    always_comb begin
        nxt_int = runState ? intS : int_ff;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            int_ff <= '0;
        end else begin
            int_ff <= nxt_int;
        end
    end

    // ----------------------------------------
    // read buffer and outputs
    // ----------------------------------------
    mwh_read_buffer u_buf (
        .clk      (clk),
        .reset_n  (reset_n),
        .flush    (flush),
        .push     (push),
        .pushData (dataS),
        .pop      (pop),
        .notEmpty (bufNotEmpty),
        .popData  (rdData),
        .popValid (rdDataValid)
    );

    assign busAddr          = addr_ff;
    assign readStrobe_n     = rdStb_ff;
    assign storeStrobe_n    = wrStb_ff;
    assign burstOrPageHit_n = bop_ff;
    assign busDriveEnable_n = drv_ff;
    assign busDataOut       = wdata_ff;
    assign busDataOe        = !drv_ff;
    assign readFault        = rdFault_ff;
    assign storeDone        = stDone_ff;
    assign intLevel         = int_ff;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_fault_release_read: assert property (
        (state_ff inside {mwh_pkg::ST_READ, mwh_pkg::ST_DRAIN}) && faultS |=> readStrobe_n && readFault)
        else $error("read strobe not released after bus fault");
    a_store_ack_ends: assert property (
        state_ff == mwh_pkg::ST_WRITE && ackS |=> storeStrobe_n && storeDone && busDriveEnable_n)
        else $error("store not ended after acknowledge");
    a_store_no_exc: assert property (
        state_ff == mwh_pkg::ST_WRITE |=> !readFault)
        else $error("exception raised on a store");
    a_capture_counts: assert property (
        state_ff == mwh_pkg::ST_READ && !faultS && capS && capCnt_ff == 3'h0 |=> capCnt_ff == 3'h1)
        else $error("captured word not counted");
    a_ack_starts_drain: assert property (
        state_ff == mwh_pkg::ST_READ && ackS && !faultS |=> state_ff == mwh_pkg::ST_DRAIN)
        else $error("acknowledge did not start draining");
    a_drain_rate: assert property (
        state_ff == mwh_pkg::ST_DRAIN && bufNotEmpty && !faultS |=> rdDataValid)
        else $error("buffer word not drained next clock");
    a_no_early_drain: assert property (
        rdDataValid |-> $past(state_ff) == mwh_pkg::ST_DRAIN)
        else $error("word drained before acknowledge or last capture");
    a_int_hold: assert property (
        !runState |=> intLevel == $past(intLevel))
        else $error("interrupt level changed outside run state");
    a_burst_mark: assert property (
        state_ff == mwh_pkg::ST_IDLE && reqValid && !reqWrite |=> burstOrPageHit_n == !$past(reqBurst))
        else $error("burst marker wrong on read");
    a_strobe_exclusive: assert property (
        !(readStrobe_n == 1'b0 && storeStrobe_n == 1'b0))
        else $error("both strobes active");

    c_single_read: cover property (
        state_ff == mwh_pkg::ST_DRAIN && !burst_ff ##1 state_ff == mwh_pkg::ST_IDLE);
    c_burst_read: cover property (
        state_ff == mwh_pkg::ST_DRAIN && burst_ff && drainCnt_ff == 3'h3 ##1 state_ff == mwh_pkg::ST_IDLE);
    c_page_store: cover property (storeDone && !$past(burstOrPageHit_n));
    c_read_fault: cover property (readFault);

endmodule // mwh_bus_interface

`default_nettype wire

// File: verification/mwh_wait_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "mwh_consts.svh"

module mwh_wait_ctrl_model (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   readStrobe_n,
    input  wire logic                   storeStrobe_n,
    input  wire logic                   burstOrPageHit_n,
    input  wire logic [`MWH_ADDR_W-1:0] busAddr,
    input  wire logic [`MWH_DATA_W-1:0] busDataOut,
    input  wire logic                   silent,
    input  wire logic                   slow,
    output logic                        readCaptureEnable_n,
    output logic                        ack_n,
    output logic                        busFaultInput_n,
    output logic [`MWH_DATA_W-1:0]      busDataIn,
    output logic [`MWH_DATA_W-1:0]      storedWord
);
    logic [3:0]  count_ff;
    logic        waitRelease_ff;
    logic [1:0]  beat_ff;
    logic [31:0] base_ff;
    logic        rd;
    logic        wr;
    logic        capHit;
    int          first;
    int          step;
    int          last;
    int          ackAt;

    // ----------------------------------------
    // cycle timing by type
    // ----------------------------------------
    // counts per cycle type
    always_comb begin
        rd = !readStrobe_n;
        wr = !storeStrobe_n;
        first = slow ? 4 : 2;
        step = slow ? 2 : 1;
        if (rd) begin
            last = burstOrPageHit_n ? first : first + 3 * step;
            ackAt = burstOrPageHit_n ? first : last - 3;
        end else begin
            last = (burstOrPageHit_n ? 3 : 2) + (slow ? 2 : 0);
            ackAt = last;
        end
        capHit = rd && int'(count_ff) >= first && int'(count_ff) <= last && (int'(count_ff) - first) % step == 0;
    end

    // ----------------------------------------
    // counter and handshake outputs
    // ----------------------------------------
    // registered active-low outputs, counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_ff <= 4'h0;
            waitRelease_ff <= 1'b0;
            beat_ff <= 2'h0;
            base_ff <= 32'h0;
            readCaptureEnable_n <= 1'b1;
            ack_n <= 1'b1;
            busFaultInput_n <= 1'b1;
            busDataIn <= 32'h0;
            storedWord <= 32'h0;
        end else begin
            readCaptureEnable_n <= 1'b1;
            ack_n <= 1'b1;
            busFaultInput_n <= 1'b1;
            // released data lines do not keep the last word
            busDataIn <= ~busDataIn;
            if (waitRelease_ff || !(rd || wr)) begin
                count_ff <= 4'h0;
                beat_ff <= 2'h0;
                waitRelease_ff <= rd || wr;
            end else if (count_ff == 4'hF) begin
                busFaultInput_n <= 1'b0;
                count_ff <= 4'h0;
                waitRelease_ff <= 1'b1;
            end else begin
                count_ff <= count_ff + 4'h1;
                if (count_ff == 4'h0) begin
                    base_ff <= busAddr;
                end
                if (!silent && capHit) begin
                    readCaptureEnable_n <= 1'b0;
                    busDataIn <= {base_ff[31:4], 2'h0, beat_ff};
                    beat_ff <= beat_ff + 2'h1;
                end
                if (!silent && int'(count_ff) == ackAt) begin
                    ack_n <= 1'b0;
                end
                if (!silent && int'(count_ff) == last) begin
                    count_ff <= 4'h0;
                    waitRelease_ff <= 1'b1;
                    if (wr) begin
                        storedWord <= busDataOut;
                    end
                end
            end
        end
    end
endmodule // mwh_wait_ctrl_model

`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mwh_consts.svh"

module tb_top;
    logic                  clk, reset_n, reqValid, reqWrite, reqBurst, runState, silent, slow;
    logic [31:0]           reqAddr, reqWrData, rdData, busAddr, busDataIn, busDataOut, storedWord;
    logic                  reqReady, rdDataValid, readFault, storeDone, readStrobe_n, storeStrobe_n;
    logic                  burstOrPageHit_n, busDriveEnable_n, busDataOe, readCaptureEnable_n, ack_n, busFaultInput_n;
    logic [`MWH_INT_W-1:0] intIn_n, intLevel;
    int                    fail_count, n_checks, cycles;

    mwh_bus_interface i_dut (.clk(clk), .reset_n(reset_n), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqBurst(reqBurst), .reqAddr(reqAddr), .reqWrData(reqWrData), .reqReady(reqReady), .rdData(rdData),
        .rdDataValid(rdDataValid), .readFault(readFault), .storeDone(storeDone), .runState(runState),
        .intLevel(intLevel), .busAddr(busAddr), .readStrobe_n(readStrobe_n), .storeStrobe_n(storeStrobe_n),
        .burstOrPageHit_n(burstOrPageHit_n), .busDriveEnable_n(busDriveEnable_n), .busDataIn(busDataIn),
        .busDataOut(busDataOut), .busDataOe(busDataOe), .readCaptureEnable_n(readCaptureEnable_n),
        .ack_n(ack_n), .busFaultInput_n(busFaultInput_n), .intIn_n(intIn_n));

    mwh_wait_ctrl_model i_mem (.clk(clk), .reset_n(reset_n), .readStrobe_n(readStrobe_n),
        .storeStrobe_n(storeStrobe_n), .burstOrPageHit_n(burstOrPageHit_n), .busAddr(busAddr),
        .busDataOut(busDataOut), .silent(silent), .slow(slow), .readCaptureEnable_n(readCaptureEnable_n),
        .ack_n(ack_n), .busFaultInput_n(busFaultInput_n), .busDataIn(busDataIn), .storedWord(storedWord));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic issue(input logic w, input logic b, input logic [31:0] a, input logic [31:0] d);
        for (int i = 0; i < 20 && reqReady !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        reqValid <= 1'b1;
        reqWrite <= w;
        reqBurst <= b;
        reqAddr <= a;
        reqWrData <= d;
        @(posedge clk);
        reqValid <= 1'b0;
    endtask

    task automatic do_read(input logic [31:0] a, input logic b, output int nw, output int span, output logic flt);
        int firstAt;
        nw = 0;
        span = 0;
        flt = 1'b0;
        firstAt = 0;
        issue(1'b0, b, a, 32'h0);
        for (int i = 0; i < 80 && !(i > 2 && reqReady === 1'b1); i++) begin
            @(posedge clk);
            #1;
            if (i == 0) check("burst_n", !b, burstOrPageHit_n);
            if (i == 0) check("readStrobe_n", 32'h0, readStrobe_n);
            if (readStrobe_n === 1'b0) check("busAddr", {a[31:2], 2'h0}, busAddr);
            if (readFault === 1'b1) flt = 1'b1;
            if (rdDataValid === 1'b1) begin
                if (nw == 0) firstAt = i;
                span = i - firstAt;
                check("rdData", {a[31:4], 2'h0, nw[1:0]}, rdData);
                nw++;
            end
        end
    endtask

    task automatic do_store(input logic [31:0] a, input logic [31:0] d, input logic hit, output int dur,
                            output logic flt);
        dur = 0;
        flt = 1'b0;
        issue(1'b1, 1'b0, a, d);
        for (int i = 1; i < 80 && dur == 0; i++) begin
            @(posedge clk);
            #1;
            if (i == 1) check("page_n", !hit, burstOrPageHit_n);
            if (i == 1) check("busDataOe", 32'h1, busDataOe);
            if (i == 1) check("storeStrobe_n", 32'h0, storeStrobe_n);
            if (i == 1) check("busDriveEnable_n", 32'h0, busDriveEnable_n);
            if (readFault === 1'b1) flt = 1'b1;
            if (storeDone === 1'b1) check("store released", 32'h1, storeStrobe_n);
            if (storeDone === 1'b1) dur = i;
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reads();
        int nw, span;
        logic flt;
        do_read(32'h0000_1237, 1'b0, nw, span, flt);
        check("single words", 32'h1, nw);
        do_read(32'h0000_2000, 1'b1, nw, span, flt);
        check("burst words", 32'h4, nw);
        check("burst span", 32'h3, span);
        slow <= 1'b1;
        do_read(32'h0000_30F0, 1'b1, nw, span, flt);
        check("slow words", 32'h4, nw);
        check("slow fault", 32'h0, flt);
        slow <= 1'b0;
    endtask

    task automatic test_stores();
        int d1, d2, d3;
        logic flt;
        do_store(32'h0000_1000, 32'hCAFE_0001, 1'b0, d1, flt);
        check("stored 1", 32'hCAFE_0001, storedWord);
        do_store(32'h0000_1008, 32'hCAFE_0002, 1'b1, d2, flt);
        check("stored 2", 32'hCAFE_0002, storedWord);
        check("near gain", 32'h1, d1 - d2);
        do_store(32'h0000_8000, 32'hCAFE_0003, 1'b0, d3, flt);
        check("far store", d1, d3);
    endtask

    task automatic test_faults();
        int nw, span, dur;
        logic flt;
        silent <= 1'b1;
        do_read(32'h0000_4000, 1'b0, nw, span, flt);
        check("fault read", 32'h1, flt);
        check("fault words", 32'h0, nw);
        do_store(32'h0000_4010, 32'h1234_5678, 1'b0, dur, flt);
        check("fault store", 32'h0, flt);
        check("store ended", 32'h1, dur > 0);
        silent <= 1'b0;
        do_read(32'h0000_5000, 1'b0, nw, span, flt);
        check("recovered", 32'h1, nw);
    endtask

    task automatic test_interrupts();
        @(posedge clk);
        intIn_n <= 6'h2A;
        repeat (5) @(posedge clk);
        #1;
        check("intLevel run", 32'h15, intLevel);
        @(posedge clk);
        runState <= 1'b0;
        intIn_n <= 6'h3F;
        repeat (5) @(posedge clk);
        #1;
        check("intLevel hold", 32'h15, intLevel);
        @(posedge clk);
        runState <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check("intLevel again", 32'h0, intLevel);
    endtask

    // ----------------------------------------
    // clock, timeout, main
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        {reset_n, reqValid, reqWrite, reqBurst, silent, slow} = 6'h0;
        {reqAddr, reqWrData, fail_count, n_checks, cycles} = '0;
        runState = 1'b1;
        intIn_n = 6'h3F;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        test_reads();
        test_stores();
        test_faults();
        test_interrupts();
        conclude();
    end
endmodule // tb_top

`default_nettype wire
